// [bench/float32_sub_mul_div_unit_tb.sv]
// self-checking bench for the float sub/mul/div unit
`include "fmu_consts.vh"

module float32_sub_mul_div_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam logic [31:0] cmdSub = 32'h0000_0011;
  localparam logic [31:0] cmdMul = 32'h0000_0012;
  localparam logic [31:0] cmdDiv = 32'h0000_0013;

  logic        mclk;
  logic        rst_b;
  wire  [7:0]  paddr;
  wire         psel;
  wire         penable;
  wire         pwrite;
  wire  [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire         irq;
  wire         faultFlag;
  wire         zeroResultFlag;
  wire         overflowFlag;
  wire         underflowFlag;
  int          failures;
  int          cmpCount;
  int          cycles;
  logic [31:0] rdData;
  logic        rdErr;
  logic [3:0]  irqEn;

  fmu_core dut (.mclk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .irq, .faultFlag, .zeroResultFlag, .overflowFlag, .underflowFlag);
  fmu_seq_model model (.mclk, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr);

  // 200 MHz
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic results();
    $display("compares %0d mismatches %0d", cmpCount, failures);
    if (failures == 0 && cmpCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // hang guard, far above the little more than a thousand cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      $display("unexpected hang at %0t: got %h expected %h", $time, cycles, 0);
      results();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      failures++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic readChk(input logic [7:0] addr, input logic [31:0] exp, input logic err);
    model.rd(addr, rdData, rdErr);
    check(rdData, exp);
    check({31'h0, rdErr}, {31'h0, err});
  endtask

  // run one command, wait while busy, then check flags, result pair and sticky status
  task automatic doOp(input logic [31:0] a, input logic [31:0] b, input logic [31:0] cmd,
                      input logic [31:0] res, input logic [3:0] flg);
    logic [3:0] stat;
    stat = flg[0] ? 4'h3 : {flg[3:2], 2'b01};
    if (!cmd[`FMU_CMD_EXEC_BIT] || cmd[1:0] == `FMU_OP_NONE) stat = 4'h0;
    model.putPair(`FMU_OFS_OPA_LO, a);
    model.putPair(`FMU_OFS_OPB_LO, b);
    model.wr(`FMU_OFS_CMD, cmd);
    rdData = 32'h0000_0100;
    while (rdData[`FMU_FLG_BUSY] !== 1'b0) model.rd(`FMU_OFS_FLAGS, rdData, rdErr);
    check(rdData, {28'h0, flg});
    check({28'h0, underflowFlag, overflowFlag, zeroResultFlag, faultFlag}, {28'h0, flg});
    readChk(`FMU_OFS_RES_LO, {16'h0, res[15:0]}, 1'b0);
    readChk(`FMU_OFS_RES_HI, {16'h0, res[31:16]}, 1'b0);
    readChk(`FMU_OFS_IRQ_STAT, {28'h0, stat}, 1'b0);
    check({31'h0, irq}, {31'h0, |(stat & irqEn)});
    model.wr(`FMU_OFS_IRQ_CLR, 32'h0000_000f);
    readChk(`FMU_OFS_IRQ_STAT, 32'h0, 1'b0);
  endtask

  initial begin
    rst_b = 1'b0;
    failures = 0;
    cmpCount = 0;
    irqEn = 4'hf;
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    // reset values, write-only command reads zero, unmapped places refused
    for (int a = 0; a <= 40; a += 4) readChk(a[7:0], 32'h0, 1'b0);
    readChk(8'h2c, 32'h0, 1'b1);
    readChk(8'h02, 32'h0, 1'b1);
    model.wr(8'hfc, 32'hffff_ffff);
    model.wr(`FMU_OFS_OPA_LO, 32'hffff_1234);
    readChk(`FMU_OFS_OPA_LO, 32'h0000_1234, 1'b0);
    model.wr(`FMU_OFS_IRQ_EN, 32'hffff_ffff);
    readChk(`FMU_OFS_IRQ_EN, 32'h0000_000f, 1'b0);
    doOp(32'h4040_0000, 32'h3f80_0000, cmdSub, 32'h4000_0000, 4'h0);
    doOp(32'h3fc0_0000, 32'h4000_0000, cmdMul, 32'h4040_0000, 4'h0);
    doOp(32'h3f80_0000, 32'h4040_0000, cmdDiv, 32'h3eaa_aaab, 4'h0);
    doOp(32'h3f80_0000, 32'h3f80_0000, cmdSub, 32'h0000_0000, 4'h2);
    doOp(32'h7f7f_ffff, 32'h4000_0000, cmdMul, 32'h7f80_0000, 4'h4);
    doOp(32'h0080_0000, 32'h3f00_0000, cmdMul, 32'h0000_0000, 4'ha);
    doOp(32'h7f80_0000, 32'h7f80_0000, cmdSub, 32'h0000_0000, 4'hb);
    doOp(32'h40a0_0000, 32'h0000_0000, cmdSub, 32'h40a0_0000, 4'h0);
    doOp(32'hff80_0000, 32'h3f80_0000, cmdSub, 32'hff80_0000, 4'h0);
    doOp(32'h3f80_0000, 32'hff80_0000, cmdSub, 32'h7f80_0000, 4'h0);
    doOp(32'h7fc0_0000, 32'h3f80_0000, cmdMul, 32'h7f80_0000, 4'h1);
    doOp(32'h0000_0000, 32'h7f80_0000, cmdMul, 32'h7f80_0000, 4'h1);
    doOp(32'h0000_0000, 32'h4040_0000, cmdMul, 32'h0000_0000, 4'h2);
    doOp(32'hc000_0000, 32'h7f80_0000, cmdMul, 32'hff80_0000, 4'h0);
    doOp(32'h0000_0000, 32'h0000_0000, cmdDiv, 32'hff80_0000, 4'h1);
    doOp(32'h7f80_0000, 32'hff80_0000, cmdDiv, 32'hff80_0000, 4'h1);
    doOp(32'h3f80_0000, 32'h0000_0000, cmdDiv, 32'h7f80_0000, 4'h0);
    doOp(32'h0000_0000, 32'h4000_0000, cmdDiv, 32'h0000_0000, 4'h2);
    doOp(32'h4000_0000, 32'hff80_0000, cmdDiv, 32'h8000_0000, 4'ha);
    doOp(32'h7f7f_ffff, 32'h3f00_0000, cmdDiv, 32'h7f80_0000, 4'h4);
    // execution condition low, and no operation selected: nothing may change
    for (int op = 1; op <= 3; op++) doOp(32'h3f80_0000, 32'h3f80_0000, op, 32'h7f80_0000, 4'h4);
    doOp(32'h3f80_0000, 32'h3f80_0000, 32'h10, 32'h7f80_0000, 4'h4);
    // pointer check: non-decimal digit, one past the area end, last valid word
    doOp(32'h4040_0000, 32'h3f80_0000, 32'h12a4_0111, 32'h7f80_0000, 4'h5);
    doOp(32'h4040_0000, 32'h3f80_0000, 32'h6144_0111, 32'h7f80_0000, 4'h5);
    doOp(32'h4040_0000, 32'h3f80_0000, 32'h6143_0111, 32'h4000_0000, 4'h0);
    // only the fault interrupt enabled: success stays quiet, fault raises the line
    irqEn = 4'h2;
    model.wr(`FMU_OFS_IRQ_EN, 32'h0000_0002);
    doOp(32'h4040_0000, 32'h4040_0000, cmdMul, 32'h4110_0000, 4'h0);
    doOp(32'h7fc0_0000, 32'h3f80_0000, cmdSub, 32'h4110_0000, 4'h1);
    results();
  end
endmodule // float32_sub_mul_div_unit_tb

// [bench/fmu_core_assertions.sv]
// port checks for the float sub/mul/div unit
`include "fmu_consts.vh"

module fmu_core_assertions (
  // clock and reset
  input wire logic        mclk,
  input wire logic        rst_b,
  // apb
  input wire logic [7:0]  paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // status
  input wire logic        irq,
  input wire logic        faultFlag,
  input wire logic        zeroResultFlag,
  input wire logic        overflowFlag,
  input wire logic        underflowFlag
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [5:0] idleCnt_q;
  logic       cmdGo;
  logic       rdAcc;
  logic       badAddr;
  logic [3:0] flagVec;

  // decoded bus events
  assign cmdGo   = psel && penable && pready && pwrite && paddr == `FMU_OFS_CMD
                   && pwdata[`FMU_CMD_EXEC_BIT] && pwdata[1:0] != `FMU_OP_NONE;
  assign rdAcc   = psel && penable && pready && !pwrite;
  assign badAddr = paddr > `FMU_OFS_IRQ_CLR || paddr[1:0] != 2'h0;
  assign flagVec = {underflowFlag, overflowFlag, zeroResultFlag, faultFlag};

  // cycles since last started operation; saturates so idle time never wraps
  always @(posedge mclk) begin
    if (!rst_b) begin
      idleCnt_q <= 6'h3f;
    end else if (cmdGo) begin
      idleCnt_q <= 6'h00;
    end else if (idleCnt_q != 6'h3f) begin
      idleCnt_q <= idleCnt_q + 6'h01;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  pready_first_a: assert property (psel && !penable |=> pready && penable)
    else $error("no answer in first access cycle");
  bad_addr_a: assert property (pready && (badAddr == pslverr) || !pready && !pslverr)
    else $error("slave error does not match address decode");
  idle_read_a: assert property (!rdAcc |-> prdata == 32'h0)
    else $error("read data outside a read access");
  flag_read_a: assert property (rdAcc && paddr == `FMU_OFS_FLAGS |-> prdata[3:0] == $past(flagVec))
    else $error("flag register disagrees with flag pins");
  flag_cause_a: assert property (!$stable(flagVec) |-> idleCnt_q <= 6'h21)
    else $error("flags moved without a started operation");
  flag_hold_a: assert property (cmdGo |=> $stable(flagVec))
    else $error("flags moved in the cycle after the command");
  fault_keep_a: assert property ($rose(faultFlag) |-> $stable(flagVec[3:1]))
    else $error("fault changed result flags");
  ovf_inf_a: assert property (overflowFlag |-> !zeroResultFlag && !underflowFlag)
    else $error("overflow with zero or underflow");
  unf_zero_a: assert property (underflowFlag |-> zeroResultFlag)
    else $error("underflow without zero result");
  irq_cause_a: assert property ($rose(irq) |-> idleCnt_q <= 6'h22 || $past(pready && pwrite, 2))
    else $error("interrupt without event or enable write");

  cover_div: cover property (cmdGo && pwdata[1:0] == `FMU_OP_DIV);
  cover_fault: cover property ($rose(faultFlag));
  cover_ovf: cover property ($rose(overflowFlag));
  cover_irq: cover property ($rose(irq));
endmodule // fmu_core_assertions

bind fmu_core fmu_core_assertions chk (.mclk, .rst_b, .paddr, .psel, .penable, .pwrite,
  .pwdata, .prdata, .pready, .pslverr, .irq, .faultFlag, .zeroResultFlag, .overflowFlag,
  .underflowFlag);

// [bench/fmu_seq_model.sv]
// apb master standing in for the controller's instruction sequencer
module fmu_seq_model (
  // clock
  input  wire logic        mclk,
  // apb request
  output logic [7:0]       paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      pwdata,
  // apb answer
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle bus from time zero so the unit never sees an unknown request
  initial begin
    paddr   = 8'h00;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    pwdata  = 32'h0;
  end

  // one transfer; request held until pready is sampled high, no fixed latency assumed
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rdata, output logic err);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= addr;
    pwdata  <= wr ? data : ~pwdata;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rdata = prdata;
    err   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwdata  <= ~pwdata;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] data);
    logic [31:0] d;
    logic        e;
    xfer(1'b1, addr, data, d, e);
  endtask

  task automatic rd(input logic [7:0] addr, output logic [31:0] data, output logic err);
    xfer(1'b0, addr, 32'h0, data, err);
  endtask

  // binary32 operand as two words, upper word (sign, exponent) one place up
  task automatic putPair(input logic [7:0] addr, input logic [31:0] v);
    wr(addr, {16'h0, v[15:0]});
    wr(addr + 8'h04, {16'h0, v[31:16]});
  endtask
endmodule // fmu_seq_model

// [hdl/fmu_consts.vh]
// constants of the float sub/mul/div unit: register map, fields, codes, counts
`ifndef FMU_CONSTS_VH
`define FMU_CONSTS_VH

// apb byte offsets
`define FMU_OFS_OPA_LO    8'h00
`define FMU_OFS_OPA_HI    8'h04
`define FMU_OFS_OPB_LO    8'h08
`define FMU_OFS_OPB_HI    8'h0c
`define FMU_OFS_CMD       8'h10
`define FMU_OFS_RES_LO    8'h14
`define FMU_OFS_RES_HI    8'h18
`define FMU_OFS_FLAGS     8'h1c
`define FMU_OFS_IRQ_STAT  8'h20
`define FMU_OFS_IRQ_EN    8'h24
`define FMU_OFS_IRQ_CLR   8'h28

// operation codes in the command register
`define FMU_OP_NONE       2'h0
`define FMU_OP_SUB        2'h1
`define FMU_OP_MUL        2'h2
`define FMU_OP_DIV        2'h3

// command register field positions
`define FMU_CMD_OP_LSB    0
`define FMU_CMD_OP_MSB    1
`define FMU_CMD_EXEC_BIT  4
`define FMU_CMD_IND_BIT   8
`define FMU_CMD_PTR_LSB   16
`define FMU_CMD_PTR_MSB   31

// flag register and interrupt bit positions
`define FMU_FLG_FAULT     0
`define FMU_FLG_ZERO      1
`define FMU_FLG_OVF       2
`define FMU_FLG_UNF       3
`define FMU_FLG_BUSY      8
`define FMU_IRQ_DONE      0
`define FMU_IRQ_FAULT     1
`define FMU_IRQ_OVF       2
`define FMU_IRQ_UNF       3

// reset values
`define FMU_RST_WORD      16'h0000
`define FMU_RST_IRQ       4'h0

// float format and timing counts
`define FMU_EXP_ALL1      8'hff
`define FMU_BIAS          11'h07f
`define FMU_DIV_BIAS      11'h07e
`define FMU_EXP_OVF       11'h0ff
`define FMU_DIV_STEPS     5'h1c
`define FMU_AREA_LAST     14'h17ff

`endif

// [hdl/fmu_core.v]
// single-precision subtract, multiply and divide unit with apb registers
//
// Notes on behaviour
// RULE_01: execution condition low means nothing happens; result and flags untouched.
// RULE_02: subtract writes minuend pair minus subtrahend pair into the result pair.
// RULE_03: multiply writes multiplicand pair times multiplier pair into the result pair.
// RULE_04: divide writes dividend pair divided by divisor pair into the result pair.
// RULE_05: software supplies both operands as single-precision binary floating values.
// RULE_06: result too large sets overflow flag and gives signed infinity.
// RULE_07: result too small sets underflow flag and gives zero.
// RULE_08: zero-result flag high exactly when result exponent and mantissa are zero.
// RULE_09: operand not a valid float sets fault flag, operation not done.
// RULE_10: indirect pointer not bcd or past area end sets fault flag.
// RULE_11: software keeps the result pair out of the reserved data-memory words.
// RULE_12: subtract specials: inf-inf same sign or nan faults; zero, infinity cases defined.
// RULE_13: multiply specials: zero times inf or nan faults; zero and infinity cases.
// RULE_14: divide specials: 0/0, inf/inf or nan fault; x/0 infinity; 0/x zero.
// RULE_15: finite divided by infinity returns zero and counts as underflow.
// RULE_16: any invalid combination sets fault flag and suppresses the result write.
// RULE_17: each 32-bit value is two 16-bit words, upper word holds sign and exponent.
// RULE_18: finite results round to nearest even; range checks use the rounded value.
//
// Implementation choices: register access over APB and the placing of the registers.
`include "fmu_consts.vh"

module fmu_core (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_b,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // status outputs
  output wire        irq,
  output wire        faultFlag,
  output wire        zeroResultFlag,
  output wire        overflowFlag,
  output wire        underflowFlag
);

  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_CHK  = 4'b0010;
  localparam [3:0] ST_DIV  = 4'b0100;
  localparam [3:0] ST_PACK = 4'b1000;

  // right shift that folds the lost bits into bit 0
  function [27:0] fmuShrSticky;
    input [27:0] v;
    input [7:0]  n;
    reg   [27:0] mask;
    begin
      mask = 28'h0000000;
      if (n >= 8'h1c) begin
        fmuShrSticky = {27'h0000000, |v};
      end else begin
        mask = ~(28'hfffffff << n);
        fmuShrSticky = (v >> n) | {27'h0000000, |(v & mask)};
      end
    end
  endfunction

  // leading zero count over the 27 low bits
  function [4:0] fmuLzc;
    input [26:0] v;
    integer      i;
    reg          found;
    begin
      fmuLzc = 5'h00;
      found = 1'b0;
      for (i = 26; i >= 0; i = i - 1) begin
        if (!found) begin
          if (v[i]) found = 1'b1;
          else fmuLzc = fmuLzc + 5'h01;
        end
      end
    end
  endfunction

  // indirect pointer check: any digit above nine or beyond the area end
  function fmuPtrBad;
    input [15:0] p;
    reg   [13:0] val;
    begin
      val = {10'h000, p[15:12]} * 14'h03e8 + {10'h000, p[11:8]} * 14'h0064
          + {10'h000, p[7:4]} * 14'h000a + {10'h000, p[3:0]};
      fmuPtrBad = (p[15:12] > 4'h9) | (p[11:8] > 4'h9) | (p[7:4] > 4'h9)
                | (p[3:0] > 4'h9) | (val > `FMU_AREA_LAST);
    end
  endfunction

  reg  [15:0] opaLo_q, opaHi_q, opbLo_q, opbHi_q, resLo_q, resHi_q;
  reg  [1:0]  op_q;
  reg         ind_q;
  reg  [15:0] ptr_q;
  reg  [31:0] opA_q, opB_q;
  reg  [3:0]  state_q;
  reg         fault_q, zero_q, ovf_q, unf_q;
  reg  [3:0]  irqStat_q, irqEn_q;
  reg         irq_q;
  reg  [27:0] man_q;
  reg  [10:0] exp_q;
  reg         sgn_q;
  reg  [31:0] prdata_q;
  reg         pready_q, pslverr_q;
  reg         divStart_q;
  wire        divDone;
  wire [27:0] divQuot;
  wire        divRemNz;
  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign irq            = irq_q;
  assign faultFlag      = fault_q;
  assign zeroResultFlag = zero_q;
  assign overflowFlag   = ovf_q;  // overflow relay of the special area
  assign underflowFlag  = unf_q;  // underflow relay of the special area

  // bus phases: zero-wait, so every access phase ends on its first edge
  wire setup = psel & ~penable;
  wire mapped = (paddr[1:0] == 2'h0) & (paddr <= `FMU_OFS_IRQ_CLR); // aligned and in range
  wire wrEn  = psel & penable & pready_q & pwrite;
  wire idle  = state_q == ST_IDLE;
  wire cmdWr = wrEn & (paddr == `FMU_OFS_CMD);
  wire [1:0] cmdOp = pwdata[`FMU_CMD_OP_MSB:`FMU_CMD_OP_LSB];
  // a command write with the condition low is dropped whole
  wire start = cmdWr & pwdata[`FMU_CMD_EXEC_BIT] & idle & (cmdOp != `FMU_OP_NONE); // see RULE_01
  // operand classification; subnormals are flushed to zero
  wire [7:0]  aE = opA_q[30:23];
  wire [7:0]  bE = opB_q[30:23];
  wire [22:0] aF = opA_q[22:0];
  wire [22:0] bF = opB_q[22:0];
  wire        aS = opA_q[31];
  wire        bS = opB_q[31];
  wire aZero = aE == 8'h00;
  wire bZero = bE == 8'h00;
  wire aInf  = (aE == `FMU_EXP_ALL1) & (aF == 23'h000000);
  wire bInf  = (bE == `FMU_EXP_ALL1) & (bF == 23'h000000);
  wire aNan  = (aE == `FMU_EXP_ALL1) & (aF != 23'h000000);
  wire bNan  = (bE == `FMU_EXP_ALL1) & (bF != 23'h000000);
  wire sx    = aS ^ bS;
  wire isSub = op_q == `FMU_OP_SUB;
  wire isMul = op_q == `FMU_OP_MUL;
  wire isDiv = op_q == `FMU_OP_DIV;
  wire faultCase = (ind_q & fmuPtrBad(ptr_q))                // see RULE_10
                 | aNan | bNan                               // see RULE_09
                 | (isSub & aInf & bInf & (aS == bS))        // see RULE_12
                 | (isMul & ((aZero & bInf) | (aInf & bZero))) // see RULE_13
                 | (isDiv & ((aZero & bZero) | (aInf & bInf))); // see RULE_14
  // special-value outcomes that skip the arithmetic
  reg        specHit;
  reg        specUnf;
  reg [31:0] specRes;
  always @* begin
    specHit = 1'b1;
    specUnf = 1'b0;
    specRes = opA_q;
    if (isSub) begin
      if (bZero) specRes = opA_q;                             // see RULE_12
      else if (aInf) specRes = opA_q;                         // see RULE_12
      else if (bInf) specRes = {~bS, `FMU_EXP_ALL1, 23'h000000}; // see RULE_12
      else if (aZero) specRes = {~bS, opB_q[30:0]};
      else specHit = 1'b0;
    end else if (isMul) begin
      if (aZero | bZero) specRes = {sx, 31'h00000000};        // see RULE_13
      else if (aInf | bInf) specRes = {sx, `FMU_EXP_ALL1, 23'h000000}; // see RULE_13
      else specHit = 1'b0;
    end else begin
      if (aZero) specRes = {sx, 31'h00000000};                // see RULE_14
      else if (bZero) specRes = {sx, `FMU_EXP_ALL1, 23'h000000}; // see RULE_14
      else if (bInf) begin
        specRes = {sx, 31'h00000000};                         // see RULE_15
        specUnf = 1'b1;
      end else if (aInf) specRes = {sx, `FMU_EXP_ALL1, 23'h000000};
      else specHit = 1'b0;
    end
  end

  // hidden bit at 26, three guard bits below the fraction
  wire [27:0] aM = {1'b0, 1'b1, aF, 3'h0};
  wire [27:0] bM = {1'b0, 1'b1, bF, 3'h0};
  wire        bBig  = {bE, bF} > {aE, aF};
  wire [27:0] bigM  = bBig ? bM : aM;
  wire [27:0] smlM  = bBig ? aM : bM;
  wire [7:0]  bigE  = bBig ? bE : aE;
  wire [7:0]  expD  = bBig ? (bE - aE) : (aE - bE);
  wire        bigS  = bBig ? ~bS : aS;  // subtrahend enters negated
  wire [27:0] smlSh = fmuShrSticky(smlM, expD);
  wire [27:0] subM  = (aS == ~bS) ? bigM + smlSh : bigM - smlSh; // see RULE_02
  wire [47:0] prod  = {1'b1, aF} * {1'b1, bF};                  // see RULE_03
  wire [27:0] mulM  = {prod[47:21], prod[20] | (|prod[19:0])};
  // normalise, round to nearest even, then range check
  reg [27:0] nm;
  reg [10:0] ne;
  reg [4:0]  lz;
  reg [24:0] rnd;
  reg        rUp;
  reg [31:0] packRes;
  reg        packOvf, packUnf;
  always @* begin
    nm = man_q;
    ne = exp_q;
    lz = 5'h00;
    packOvf = 1'b0;
    packUnf = 1'b0;
    if (nm[27]) begin
      nm = fmuShrSticky(nm, 8'h01);
      ne = ne + 11'h001;
    end else begin
      lz = fmuLzc(nm[26:0]);
      nm = nm << lz;
      ne = ne - {6'h00, lz};
    end
    rUp = nm[2] & (nm[3] | nm[1] | nm[0]);                 // see RULE_18
    rnd = {1'b0, nm[26:3]} + {24'h000000, rUp};
    if (rnd[24]) ne = ne + 11'h001;
    packRes = {sgn_q, ne[7:0], rnd[24] ? rnd[23:1] : rnd[22:0]};
    if (man_q == 28'h0000000) begin
      packRes = 32'h00000000;                              // exact cancellation
    end else if (!ne[10] && ne >= `FMU_EXP_OVF) begin
      packRes = {sgn_q, `FMU_EXP_ALL1, 23'h000000};        // see RULE_06
      packOvf = 1'b1;
    end else if (ne[10] || ne == 11'h000) begin
      packRes = {sgn_q, 31'h00000000};                     // see RULE_07
      packUnf = 1'b1;
    end
  end

  // one write path for every outcome that stores a result
  wire        wrRes  = (state_q == ST_CHK & ~faultCase & specHit) | (state_q == ST_PACK);
  wire [31:0] newRes = (state_q == ST_PACK) ? packRes : specRes;
  wire        newOvf = (state_q == ST_PACK) & packOvf;
  wire        newUnf = (state_q == ST_PACK) ? packUnf : specUnf;
  wire        evFault = (state_q == ST_CHK) & faultCase;
  wire [3:0]  events = {wrRes & newUnf, wrRes & newOvf, evFault, wrRes | evFault};
  wire [3:0]  irqClr = (wrEn & (paddr == `FMU_OFS_IRQ_CLR)) ? pwdata[3:0] : 4'h0;
  wire [3:0]  irqNext = (irqStat_q & ~irqClr) | events; // set beats clear

  // sequencer and result / flag registers
  always @(posedge mclk) begin
    if (!rst_b) begin
      state_q    <= ST_IDLE;
      op_q       <= `FMU_OP_NONE;
      ind_q      <= 1'b0;
      ptr_q      <= `FMU_RST_WORD;
      opA_q      <= 32'h00000000;
      opB_q      <= 32'h00000000;
      resLo_q    <= `FMU_RST_WORD;
      resHi_q    <= `FMU_RST_WORD;
      fault_q    <= 1'b0;
      zero_q     <= 1'b0;
      ovf_q      <= 1'b0;
      unf_q      <= 1'b0;
      man_q      <= 28'h0000000;
      exp_q      <= 11'h000;
      sgn_q      <= 1'b0;
      divStart_q <= 1'b0;
    end else begin
      divStart_q <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            op_q    <= cmdOp;
            ind_q   <= pwdata[`FMU_CMD_IND_BIT];
            ptr_q   <= pwdata[`FMU_CMD_PTR_MSB:`FMU_CMD_PTR_LSB];
            opA_q   <= {opaHi_q, opaLo_q}; // see RULE_17
            opB_q   <= {opbHi_q, opbLo_q}; // see RULE_17
            state_q <= ST_CHK;
          end
        end
        ST_CHK: begin
          if (faultCase) begin
            fault_q <= 1'b1;               // see RULE_16
            state_q <= ST_IDLE;
          end else if (specHit) begin
            state_q <= ST_IDLE;
          end else if (isSub) begin
            man_q   <= subM;
            exp_q   <= {3'h0, bigE};
            sgn_q   <= bigS;
            state_q <= ST_PACK;
          end else if (isMul) begin
            man_q   <= mulM;
            exp_q   <= {3'h0, aE} + {3'h0, bE} - `FMU_BIAS;
            sgn_q   <= sx;
            state_q <= ST_PACK;
          end else begin
            exp_q      <= {3'h0, aE} - {3'h0, bE} + `FMU_DIV_BIAS; // see RULE_04
            sgn_q      <= sx;
            divStart_q <= 1'b1;
            state_q    <= ST_DIV;
          end
        end
        ST_DIV: begin
          if (divDone) begin
            man_q   <= {divQuot[27:1], divQuot[0] | divRemNz};
            state_q <= ST_PACK;
          end
        end
        ST_PACK: state_q <= ST_IDLE;
        default: state_q <= ST_IDLE;
      endcase
      if (wrRes) begin
        resLo_q <= newRes[15:0];
        resHi_q <= newRes[31:16];
        fault_q <= 1'b0;
        zero_q  <= newRes[30:0] == 31'h00000000; // see RULE_08
        ovf_q   <= newOvf;
        unf_q   <= newUnf;
      end
    end
  end

  // software-written registers and interrupt status
  always @(posedge mclk) begin
    if (!rst_b) begin
      opaLo_q   <= `FMU_RST_WORD;
      opaHi_q   <= `FMU_RST_WORD;
      opbLo_q   <= `FMU_RST_WORD;
      opbHi_q   <= `FMU_RST_WORD;
      irqEn_q   <= `FMU_RST_IRQ;
      irqStat_q <= `FMU_RST_IRQ;
      irq_q     <= 1'b0;
    end else begin
      if (wrEn && paddr == `FMU_OFS_OPA_LO) opaLo_q <= pwdata[15:0];
      if (wrEn && paddr == `FMU_OFS_OPA_HI) opaHi_q <= pwdata[15:0];
      if (wrEn && paddr == `FMU_OFS_OPB_LO) opbLo_q <= pwdata[15:0];
      if (wrEn && paddr == `FMU_OFS_OPB_HI) opbHi_q <= pwdata[15:0];
      if (wrEn && paddr == `FMU_OFS_IRQ_EN) irqEn_q <= pwdata[3:0];
      irqStat_q <= irqNext;
      irq_q     <= |(irqNext & irqEn_q);
    end
  end

  // read mux sampled in the setup cycle
  reg [31:0] rdMux;
  always @* begin
    case (paddr)
      `FMU_OFS_OPA_LO:   rdMux = {16'h0000, opaLo_q};
      `FMU_OFS_OPA_HI:   rdMux = {16'h0000, opaHi_q};
      `FMU_OFS_OPB_LO:   rdMux = {16'h0000, opbLo_q};
      `FMU_OFS_OPB_HI:   rdMux = {16'h0000, opbHi_q};
      `FMU_OFS_RES_LO:   rdMux = {16'h0000, resLo_q};
      `FMU_OFS_RES_HI:   rdMux = {16'h0000, resHi_q};
      `FMU_OFS_FLAGS:    rdMux = {23'h000000, ~idle, 4'h0, unf_q, ovf_q, zero_q, fault_q};
      `FMU_OFS_IRQ_STAT: rdMux = {28'h0000000, irqStat_q};
      `FMU_OFS_IRQ_EN:   rdMux = {28'h0000000, irqEn_q};
      default:           rdMux = 32'h00000000; // command and clear read as zero
    endcase
  end

  // apb answer flops; unmapped addresses answer with an error
  always @(posedge mclk) begin
    if (!rst_b) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q  <= (setup & ~pwrite) ? rdMux : 32'h00000000;
    end
  end
  fmu_divider uDiv (.mclk(mclk), .rst_b(rst_b), .start(divStart_q), .dividend({1'b1, aF}),
    .divisor({1'b1, bF}), .done_q(divDone), .quot_q(divQuot), .remNonZero_q(divRemNz));
endmodule // fmu_core

// [hdl/fmu_divider.v]
// restoring mantissa divider, one quotient bit per clock
`include "fmu_consts.vh"

module fmu_divider (
  // clock and reset
  input  wire        mclk,
  input  wire        rst_b,
  // request
  input  wire        start,
  input  wire [23:0] dividend,
  input  wire [23:0] divisor,
  // answer
  output reg         done_q,
  output reg  [27:0] quot_q,
  output reg         remNonZero_q
);

  reg  [24:0] rem_q;
  reg  [4:0]  cnt_q;
  reg         run_q;
  wire        geq     = rem_q >= {1'b0, divisor};
  wire [24:0] diff    = rem_q - {1'b0, divisor};
  wire [24:0] nextRem = geq ? diff : rem_q;

  // first bit has weight one; quotient stays below two
  always @(posedge mclk) begin
    if (!rst_b) begin
      rem_q        <= 25'h0000000;
      cnt_q        <= 5'h00;
      run_q        <= 1'b0;
      done_q       <= 1'b0;
      quot_q       <= 28'h0000000;
      remNonZero_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        rem_q  <= {1'b0, dividend};
        quot_q <= 28'h0000000;
        cnt_q  <= `FMU_DIV_STEPS;
        run_q  <= 1'b1;
      end else if (run_q) begin
        quot_q <= {quot_q[26:0], geq};
        rem_q  <= {nextRem[23:0], 1'b0}; // remainder below divisor, top bit free
        cnt_q  <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          run_q        <= 1'b0;
          done_q       <= 1'b1;
          remNonZero_q <= |nextRem; // sticky for rounding
        end
      end
    end
  end

endmodule // fmu_divider
